// ==== rtl/tmwm_pkg.sv ====
// Constants for the timer waveform mode control block.
// Assumes a 32-bit APB bus and a counter elsewhere on the same clock.
package tmwm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] TMWM_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] TMWM_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] TMWM_OFF_STATUS = 8'h08;
  localparam logic [7:0] TMWM_RST_CTRL   = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TMWM_A_COMA_HI = 7;
  localparam int TMWM_A_COMA_LO = 6;
  localparam int TMWM_A_COMB_HI = 5;
  localparam int TMWM_A_COMB_LO = 4;
  localparam int TMWM_A_FRC_A   = 3;
  localparam int TMWM_A_FRC_B   = 2;
  localparam int TMWM_A_WGM_HI  = 1;
  localparam int TMWM_A_WGM_LO  = 0;
  localparam int TMWM_B_FILT    = 7;
  localparam int TMWM_B_EDGE    = 6;
  localparam int TMWM_B_RSVD    = 5;
  localparam int TMWM_B_WGM_HI  = 4;
  localparam int TMWM_B_WGM_LO  = 3;
  localparam int TMWM_B_CS_HI   = 2;
  localparam int TMWM_B_CS_LO   = 0;

  // ****************************************************************
  // Waveform modes, classes and decoded points
  // ****************************************************************
  localparam logic [3:0] TMWM_M_NORMAL = 4'h0;
  localparam logic [3:0] TMWM_M_PC8    = 4'h1;
  localparam logic [3:0] TMWM_M_PC9    = 4'h2;
  localparam logic [3:0] TMWM_M_PC10   = 4'h3;
  localparam logic [3:0] TMWM_M_CTC_A  = 4'h4;
  localparam logic [3:0] TMWM_M_FP8    = 4'h5;
  localparam logic [3:0] TMWM_M_FP9    = 4'h6;
  localparam logic [3:0] TMWM_M_FP10   = 4'h7;
  localparam logic [3:0] TMWM_M_PFC_C  = 4'h8;
  localparam logic [3:0] TMWM_M_PFC_A  = 4'h9;
  localparam logic [3:0] TMWM_M_PC_C   = 4'hA;
  localparam logic [3:0] TMWM_M_PC_A   = 4'hB;
  localparam logic [3:0] TMWM_M_CTC_C  = 4'hC;
  localparam logic [3:0] TMWM_M_RSVD   = 4'hD;
  localparam logic [3:0] TMWM_M_FP_C   = 4'hE;
  localparam logic [3:0] TMWM_M_FP_A   = 4'hF;

  localparam logic [1:0] TMWM_CLS_NON  = 2'h0;
  localparam logic [1:0] TMWM_CLS_FAST = 2'h1;
  localparam logic [1:0] TMWM_CLS_DUAL = 2'h2;

  localparam logic [1:0] TMWM_TOP_FIXED = 2'h0;
  localparam logic [1:0] TMWM_TOP_CMPA  = 2'h1;
  localparam logic [1:0] TMWM_TOP_CAPT  = 2'h2;

  localparam logic [1:0] TMWM_PT_IMMED  = 2'h0;
  localparam logic [1:0] TMWM_PT_TOP    = 2'h1;
  localparam logic [1:0] TMWM_PT_BOTTOM = 2'h2;
  localparam logic [1:0] TMWM_PT_MAX    = 2'h3;

  localparam logic [15:0] TMWM_TOP_16 = 16'hFFFF;
  localparam logic [15:0] TMWM_TOP_8  = 16'h00FF;
  localparam logic [15:0] TMWM_TOP_9  = 16'h01FF;
  localparam logic [15:0] TMWM_TOP_10 = 16'h03FF;

  // ****************************************************************
  // Compare output codes and clock select codes
  // ****************************************************************
  localparam logic [1:0] TMWM_COM_OFF = 2'h0;
  localparam logic [1:0] TMWM_COM_TOG = 2'h1;
  localparam logic [1:0] TMWM_COM_CLR = 2'h2;
  localparam logic [1:0] TMWM_COM_SET = 2'h3;

  localparam logic [2:0] TMWM_CS_STOP = 3'h0;
  localparam logic [2:0] TMWM_CS_D1   = 3'h1;
  localparam logic [2:0] TMWM_CS_D8   = 3'h2;
  localparam logic [2:0] TMWM_CS_D64  = 3'h3;
  localparam logic [2:0] TMWM_CS_D256 = 3'h4;
  localparam logic [2:0] TMWM_CS_D1K  = 3'h5;
  localparam logic [2:0] TMWM_CS_EXTF = 3'h6;
  localparam logic [2:0] TMWM_CS_EXTR = 3'h7;

  localparam int TMWM_PSC_W   = 10;
  localparam int TMWM_DIV8_B  = 3;
  localparam int TMWM_DIV64_B = 6;
  localparam int TMWM_DIV256_B = 8;
  localparam int TMWM_FILT_N  = 4;

endpackage : tmwm_pkg

// ==== rtl/tmwm_ctrl.sv ====
// Control registers and waveform decode for a 16-bit timer.
// Assumes the counter, its compare flags and its direction come from
// logic on pclk; the capture and external clock pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module tmwm_ctrl
  import tmwm_pkg::*;
#(
  parameter int PSC_W = tmwm_pkg::TMWM_PSC_W
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Counter status on pclk.
  input  wire logic        match_a,
  input  wire logic        match_b,
  input  wire logic        at_bottom,
  input  wire logic        count_down,
  input  wire logic        cmp_a_is_top,
  input  wire logic        cmp_b_is_top,
  input  wire logic        dir_a,
  input  wire logic        dir_b,
  // Asynchronous pins.
  input  wire logic        capture_pin,
  input  wire logic        ext_clk_pin,
  // Compare pins.
  output var  logic        compare_out_a,
  output var  logic        compare_out_b,
  output var  logic        override_a,
  output var  logic        override_b,
  output var  logic        pin_oe_n_a,
  output var  logic        pin_oe_n_b,
  // Decoded control for the counter.
  output var  logic        timer_tick,
  output var  logic        capture_event,
  output var  logic [1:0]  top_source,
  output var  logic [15:0] top_fixed,
  output var  logic [1:0]  update_point,
  output var  logic [1:0]  overflow_point,
  output var  logic        dual_slope
);

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic logic [1:0] mode_cls(input logic [3:0] m);
    logic [1:0] c;
    c = TMWM_CLS_NON;
    case (m)
      TMWM_M_FP8, TMWM_M_FP9, TMWM_M_FP10, TMWM_M_FP_C,
      TMWM_M_FP_A: c = TMWM_CLS_FAST;
      TMWM_M_PC8, TMWM_M_PC9, TMWM_M_PC10, TMWM_M_PFC_C,
      TMWM_M_PFC_A, TMWM_M_PC_C, TMWM_M_PC_A: c = TMWM_CLS_DUAL;
      default: c = TMWM_CLS_NON;
    endcase
    return c;
  endfunction : mode_cls

  function automatic logic tog_ok(input logic [3:0] m,
                                  input logic       chan_a);
    logic ok;
    ok = 1'b1;
    case (mode_cls(m))
      TMWM_CLS_FAST: ok = chan_a && (m == TMWM_M_FP_A);
      TMWM_CLS_DUAL: ok = chan_a && (m == TMWM_M_PFC_A ||
                                     m == TMWM_M_FP_C);
      default:       ok = 1'b1;
    endcase
    return ok;
  endfunction : tog_ok

  function automatic logic connected(input logic [3:0] m,
                                     input logic [1:0] com,
                                     input logic       chan_a);
    return (com != TMWM_COM_OFF) &&
           ((com != TMWM_COM_TOG) || tog_ok(m, chan_a));
  endfunction : connected

  function automatic logic wave_next(input logic       cur,
                                     input logic [1:0] com,
                                     input logic [3:0] m,
                                     input logic       chan_a,
                                     input logic       hit,
                                     input logic       bot,
                                     input logic       down,
                                     input logic       cmp_top,
                                     input logic       frc);
    logic n;
    n = cur;
    case (mode_cls(m))
      TMWM_CLS_NON: begin
        if (hit || frc) begin
          case (com)
            TMWM_COM_TOG: n = !cur;
            TMWM_COM_CLR: n = 1'b0;
            TMWM_COM_SET: n = 1'b1;
            default:      n = cur;
          endcase
        end
      end
      TMWM_CLS_FAST: begin
        if (com == TMWM_COM_TOG) begin
          if (hit && tog_ok(m, chan_a)) n = !cur;
        end else if (com[1]) begin
          if (bot) n = !com[0];
          if (hit && !cmp_top) n = com[0];
        end
      end
      TMWM_CLS_DUAL: begin
        if (com == TMWM_COM_TOG) begin
          if (hit && tog_ok(m, chan_a)) n = !cur;
        end else if (com[1] && hit) begin
          n = com[0] ^ down;
        end
      end
      default: n = cur;
    endcase
    return n;
  endfunction : wave_next

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (PSC_W < TMWM_PSC_W) begin : g_chk
    $error("Prescaler too narrow for the largest divide.");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic       force_a_q;
  logic       force_b_q;
  logic [3:0] mode;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] clk_sel;
  logic       filt_en;
  logic       edge_rise;
  logic       setup;
  logic       wr_en;
  logic       hit_a;
  logic       hit_b;
  logic       non_pwm;
  logic       top_capt;
  logic [7:0] wbyte;

  assign mode     = {ctrl_b_q[TMWM_B_WGM_HI:TMWM_B_WGM_LO],
                     ctrl_a_q[TMWM_A_WGM_HI:TMWM_A_WGM_LO]};
  assign com_a    = ctrl_a_q[TMWM_A_COMA_HI:TMWM_A_COMA_LO];
  assign com_b    = ctrl_a_q[TMWM_A_COMB_HI:TMWM_A_COMB_LO];
  assign clk_sel  = ctrl_b_q[TMWM_B_CS_HI:TMWM_B_CS_LO];
  assign filt_en  = ctrl_b_q[TMWM_B_FILT];
  assign edge_rise = ctrl_b_q[TMWM_B_EDGE];
  assign setup    = psel && !penable && !pready;
  assign wr_en    = psel && penable && pready && pwrite;
  assign wbyte    = pwdata[7:0];
  assign non_pwm  = mode_cls(mode) == TMWM_CLS_NON;
  assign top_capt = (mode == TMWM_M_PFC_C) || (mode == TMWM_M_PC_C) ||
                    (mode == TMWM_M_CTC_C) || (mode == TMWM_M_FP_C);

  // Control registers; force and reserved bits are never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= TMWM_RST_CTRL;
      ctrl_b_q <= TMWM_RST_CTRL;
    end else if (wr_en) begin
      if (paddr == TMWM_OFF_CTRL_A) begin
        ctrl_a_q <= wbyte;
        ctrl_a_q[TMWM_A_FRC_A] <= 1'b0;
        ctrl_a_q[TMWM_A_FRC_B] <= 1'b0;
      end
      if (paddr == TMWM_OFF_CTRL_B) begin
        ctrl_b_q <= wbyte;
        ctrl_b_q[TMWM_B_RSVD] <= 1'b0;
      end
    end
  end

  // Force strobes: one-cycle pulses taken only in non-PWM modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_a_q <= 1'b0;
      force_b_q <= 1'b0;
    end else begin
      force_a_q <= wr_en && paddr == TMWM_OFF_CTRL_A &&
                   wbyte[TMWM_A_FRC_A] && non_pwm;
      force_b_q <= wr_en && paddr == TMWM_OFF_CTRL_A &&
                   wbyte[TMWM_A_FRC_B] && non_pwm;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (setup) begin
        case (paddr)
          TMWM_OFF_CTRL_A: prdata[7:0] <= ctrl_a_q;
          TMWM_OFF_CTRL_B: prdata[7:0] <= ctrl_b_q;
          TMWM_OFF_STATUS: prdata[7:0] <= {2'h0, dual_slope, override_b,
                                           override_a, compare_out_b,
                                           compare_out_a, timer_tick};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_source     <= TMWM_TOP_FIXED;
      top_fixed      <= TMWM_TOP_16;
      update_point   <= TMWM_PT_IMMED;
      overflow_point <= TMWM_PT_MAX;
      dual_slope     <= 1'b0;
    end else begin
      dual_slope <= mode_cls(mode) == TMWM_CLS_DUAL;
      top_fixed  <= TMWM_TOP_16;
      case (mode_cls(mode))
        TMWM_CLS_FAST: begin
          update_point   <= TMWM_PT_BOTTOM;
          overflow_point <= TMWM_PT_TOP;
        end
        TMWM_CLS_DUAL: begin
          overflow_point <= TMWM_PT_BOTTOM;
          update_point   <= (mode == TMWM_M_PFC_C || mode == TMWM_M_PFC_A)
                            ? TMWM_PT_BOTTOM : TMWM_PT_TOP;
        end
        default: begin
          update_point   <= TMWM_PT_IMMED;
          overflow_point <= TMWM_PT_MAX;
        end
      endcase
      case (mode)
        TMWM_M_PC8,  TMWM_M_FP8:  top_fixed <= TMWM_TOP_8;
        TMWM_M_PC9,  TMWM_M_FP9:  top_fixed <= TMWM_TOP_9;
        TMWM_M_PC10, TMWM_M_FP10: top_fixed <= TMWM_TOP_10;
        default: top_fixed <= TMWM_TOP_16;
      endcase
      if (top_capt) top_source <= TMWM_TOP_CAPT;
      else if (mode == TMWM_M_CTC_A || mode == TMWM_M_PFC_A ||
               mode == TMWM_M_PC_A || mode == TMWM_M_FP_A)
        top_source <= TMWM_TOP_CMPA;
      else top_source <= TMWM_TOP_FIXED;
    end
  end

  // ****************************************************************
  // Compare outputs and pin control
  // ****************************************************************
  // A forced match only reaches the waveform; no flag or clear leaves.
  assign hit_a = match_a;
  assign hit_b = match_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end else begin
      compare_out_a <= wave_next(compare_out_a, com_a, mode, 1'b1, hit_a,
                                 at_bottom, count_down, cmp_a_is_top,
                                 force_a_q);
      compare_out_b <= wave_next(compare_out_b, com_b, mode, 1'b0, hit_b,
                                 at_bottom, count_down, cmp_b_is_top,
                                 force_b_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override_a <= 1'b0;
      override_b <= 1'b0;
      pin_oe_n_a <= 1'b1;
      pin_oe_n_b <= 1'b1;
    end else begin
      override_a <= connected(mode, com_a, 1'b1);
      override_b <= connected(mode, com_b, 1'b0);
      pin_oe_n_a <= !(connected(mode, com_a, 1'b1) && dir_a);
      pin_oe_n_b <= !(connected(mode, com_b, 1'b0) && dir_b);
    end
  end

  // ****************************************************************
  // Clock select and prescaler
  // ****************************************************************
  logic [PSC_W-1:0] psc_q;
  logic [2:0]       ext_q;
  logic             tick_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= '0;
      ext_q <= '0;
    end else begin
      psc_q <= (clk_sel == TMWM_CS_STOP) ? '0 : psc_q + 1'b1;
      ext_q <= {ext_q[1:0], ext_clk_pin};
    end
  end

  always_comb begin
    tick_d = 1'b0;
    case (clk_sel)
      TMWM_CS_D1:   tick_d = 1'b1;
      TMWM_CS_D8:   tick_d = &psc_q[TMWM_DIV8_B-1:0];
      TMWM_CS_D64:  tick_d = &psc_q[TMWM_DIV64_B-1:0];
      TMWM_CS_D256: tick_d = &psc_q[TMWM_DIV256_B-1:0];
      TMWM_CS_D1K:  tick_d = &psc_q[TMWM_PSC_W-1:0];
      TMWM_CS_EXTF: tick_d = ext_q[2] && !ext_q[1];
      TMWM_CS_EXTR: tick_d = !ext_q[2] && ext_q[1];
      default:      tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_tick <= 1'b0;
    else          timer_tick <= tick_d;
  end

  // ****************************************************************
  // Capture input filter and edge detect
  // ****************************************************************
  logic [1:0]             cap_sync_q;
  logic [TMWM_FILT_N-1:0] cap_hist_q;
  logic                   cap_filt_q;
  logic                   cap_next;

  assign cap_next = filt_en ? ((&cap_hist_q) ? 1'b1 :
                               (~|cap_hist_q) ? 1'b0 : cap_filt_q)
                            : cap_sync_q[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sync_q    <= '0;
      cap_hist_q    <= '0;
      cap_filt_q    <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      cap_sync_q <= {cap_sync_q[0], capture_pin};
      cap_hist_q <= {cap_hist_q[TMWM_FILT_N-2:0], cap_sync_q[1]};
      cap_filt_q <= cap_next;
      capture_event <= !top_capt && (cap_next != cap_filt_q) &&
                       (cap_next == edge_rise);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_FORCE_READ_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && paddr == TMWM_OFF_CTRL_A |=> prdata[3:2] == 2'h0)
    else $error("Force bits read back nonzero.");

  AST_RSVD_READ_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && paddr == TMWM_OFF_CTRL_B |=> !prdata[5])
    else $error("Reserved bit reads nonzero.");

  AST_FORCE_PWM_BLOCK: assert property (
    @(posedge pclk) disable iff (!presetn)
    force_a_q && !non_pwm && !match_a && !at_bottom
    |=> compare_out_a == $past(compare_out_a))
    else $error("Force strobe taken in a PWM mode.");

  AST_FORCE_PULSE: assert property (
    @(posedge pclk) disable iff (!presetn)
    force_a_q |=> !force_a_q && !ctrl_a_q[TMWM_A_FRC_A])
    else $error("Force strobe persisted.");

  AST_OE_FOLLOWS_DIR: assert property (
    @(posedge pclk) disable iff (!presetn)
    !dir_a |=> pin_oe_n_a)
    else $error("Pin driven without direction bit.");

  AST_NONPWM_TOGGLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    non_pwm && com_a == TMWM_COM_TOG && match_a
    |=> compare_out_a != $past(compare_out_a))
    else $error("Toggle on match missed.");

  AST_FAST_BOTTOM_SET: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_cls(mode) == TMWM_CLS_FAST && com_a == TMWM_COM_CLR &&
    at_bottom && (!match_a || cmp_a_is_top) |=> compare_out_a)
    else $error("Non-inverting fast output not set at bottom.");

  AST_DUAL_DOWN_SET: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_cls(mode) == TMWM_CLS_DUAL && com_b == TMWM_COM_CLR &&
    match_b && count_down |=> compare_out_b)
    else $error("Dual-slope output not set on down match.");

  AST_TOP_8BIT: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode == TMWM_M_PC8 ##1 mode == TMWM_M_PC8
    |-> top_fixed == TMWM_TOP_8 && update_point == TMWM_PT_TOP)
    else $error("Phase correct 8-bit decode wrong.");

  AST_STOPPED: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_sel == TMWM_CS_STOP |=> !timer_tick)
    else $error("Tick while clock stopped.");

  AST_FILTER_STABLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(filt_en) && cap_filt_q != $past(cap_filt_q)
    |-> $past(&cap_hist_q) || $past(~|cap_hist_q))
    else $error("Filter changed without four equal samples.");

  AST_CAPT_DISABLED: assert property (
    @(posedge pclk) disable iff (!presetn)
    top_capt |=> !capture_event)
    else $error("Capture while capture register is top.");

endmodule : tmwm_ctrl

`default_nettype wire

// ==== bench/tmwm_pin_model.sv ====
// Pin model for the two compare pads and the capture pin.
// Assumes both pads carry a pull-up when nothing drives them.
`timescale 1ns/100ps
`default_nettype none
module tmwm_pin_model (
  // Compare side.
  input  wire logic compare_out_a,
  input  wire logic pin_oe_n_a,
  input  wire logic compare_out_b,
  input  wire logic pin_oe_n_b,
  // Capture side.
  input  wire logic cap_lvl,
  output var  logic pad_a,
  output var  logic pad_b,
  output var  logic capture_pin
);
  // Undriven pads rise to the pull-up level.
  assign pad_a = pin_oe_n_a ? 1'h1 : compare_out_a;
  assign pad_b = pin_oe_n_b ? 1'h1 : compare_out_b;
  assign capture_pin = cap_lvl;
endmodule : tmwm_pin_model
`default_nettype wire

// ==== bench/timer16_waveform_mode_control_tb.sv ====
// Self-checking bench for the timer control block.
// Assumes the pin model and the block run on one clock.
`timescale 1ns/100ps
`default_nettype none
module timer16_waveform_mode_control_tb;
  import tmwm_pkg::*;
  localparam logic [31:0] TS = 32'h6266_0100;
  localparam logic [31:0] UP = 32'hA05A_A854;
  localparam logic [31:0] OV = 32'h53AA_57AB;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        match_a = 0, match_b = 0, at_bottom = 0, count_down = 0;
  logic        cmp_a_is_top = 0, cmp_b_is_top = 0, dir_a = 0, dir_b = 0;
  logic        ext_clk_pin = 0, cap_lvl = 0, capture_pin, pad_a, pad_b;
  logic [7:0]  paddr = 0, v;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, compare_out_a, compare_out_b, override_a;
  logic        override_b, pin_oe_n_a, pin_oe_n_b, timer_tick, capture_event;
  logic        dual_slope;
  logic [1:0]  top_source, update_point, overflow_point;
  logic [15:0] top_fixed;
  logic [32:0] exp_q[$];
  int          bad_count = 0, checked = 0, cap_n = 0, tick_n = 0;
  integer      seed = 32'h97c9;
  tmwm_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .match_a, .match_b, .at_bottom,
    .count_down, .cmp_a_is_top, .cmp_b_is_top, .dir_a, .dir_b,
    .capture_pin, .ext_clk_pin, .compare_out_a, .compare_out_b,
    .override_a, .override_b, .pin_oe_n_a, .pin_oe_n_b, .timer_tick,
    .capture_event, .top_source, .top_fixed, .update_point,
    .overflow_point, .dual_slope);
  tmwm_pin_model pin_u (.compare_out_a, .pin_oe_n_a, .compare_out_b,
    .pin_oe_n_b, .cap_lvl, .pad_a, .pad_b, .capture_pin);
  initial forever #25 pclk = ~pclk;
  task chk(input string n, input logic [32:0] e, s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 8'h00);
  endtask : rd
  task pin(input logic b, h, e);
    @(posedge pclk);
    at_bottom <= b;
    match_a <= h;
    match_b <= h;
    @(posedge pclk);
    at_bottom <= 0;
    match_a <= 0;
    match_b <= 0;
    repeat (2) @(posedge pclk);
    chk("out_a", e, compare_out_a);
  endtask : pin
  task report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite)
      chk("read", exp_q.pop_front(), {pslverr, prdata});
    if (capture_event === 1'h1) cap_n++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(8'h00, 0);
    rd(8'h04, 0);
    apb(1, 8'h00, 8'hFC);
    rd(8'h00, 8'hF0);
    rd(8'h0C, {1'h1, 32'h0});
    repeat (4) begin
      v = 8'($random(seed));
      apb(1, 8'h04, v);
      rd(8'h04, v & 8'hDF);
    end
    for (int m = 0; m < 16; m++) if (m != 13) begin
      apb(1, 8'h00, {6'h0, m[1:0]});
      apb(1, 8'h04, {3'h0, m[3:2], 3'h0});
      repeat (2) @(posedge pclk);
      chk("top_src", TS[2*m +: 2], top_source);
      chk("update", UP[2*m +: 2], update_point);
      chk("ovf", OV[2*m +: 2], overflow_point);
      chk("dual", (m > 0 && m < 4) || (m > 7 && m < 12), dual_slope);
      if (TS[2*m +: 2] == 0)
        chk("top", m[1:0] == 0 ? 16'hFFFF : (16'h80 << m[1:0]) - 1,
            top_fixed);
    end
    dir_a <= 1;
    apb(1, 8'h00, 8'h00);
    apb(1, 8'h04, 8'h00);
    apb(1, 8'h00, 8'hAC);
    pin(0, 0, 0);
    chk("oe_a", 0, pin_oe_n_a);
    chk("pad_a", 0, pad_a);
    chk("ovr_b", 1, override_b);
    chk("oe_b", 1, pin_oe_n_b);
    chk("pad_b", 1, pad_b);
    chk("out_b", 0, compare_out_b);
    apb(1, 8'h00, 8'hC8);
    pin(0, 0, 1);
    apb(1, 8'h00, 8'h40);
    pin(0, 1, 0);
    pin(0, 1, 1);
    apb(1, 8'h04, 8'h18);
    apb(1, 8'h00, 8'h8A);
    pin(0, 0, 1);
    pin(0, 1, 0);
    pin(1, 0, 1);
    cmp_a_is_top <= 1;
    pin(0, 1, 1);
    cmp_a_is_top <= 0;
    apb(1, 8'h04, 8'h10);
    apb(1, 8'h00, 8'hA1);
    pin(0, 1, 0);
    count_down <= 1;
    pin(0, 1, 1);
    chk("out_b", 1, compare_out_b);
    apb(1, 8'h00, 8'h41);
    pin(0, 1, 0);
    count_down <= 0;
    apb(1, 8'h04, 8'h18);
    apb(1, 8'h00, 8'h43);
    pin(0, 1, 1);
    apb(1, 8'h00, 8'h00);
    apb(1, 8'h04, 8'h40);
    repeat (2) @(posedge pclk);
    chk("ovr_a", 0, override_a);
    cap_lvl <= 1;
    repeat (10) @(posedge pclk);
    chk("cap", 1, cap_n);
    cap_lvl <= 0;
    repeat (10) @(posedge pclk);
    chk("cap", 1, cap_n);
    apb(1, 8'h04, 8'hC0);
    cap_lvl <= 1;
    repeat (2) @(posedge pclk);
    cap_lvl <= 0;
    repeat (10) @(posedge pclk);
    chk("cap", 1, cap_n);
    cap_lvl <= 1;
    repeat (12) @(posedge pclk);
    chk("cap", 2, cap_n);
    apb(1, 8'h04, 8'h80);
    cap_lvl <= 0;
    repeat (12) @(posedge pclk);
    chk("cap", 3, cap_n);
    apb(1, 8'h04, 8'h02);
    do @(posedge pclk); while (timer_tick !== 1'h1);
    tick_n = 0;
    do begin
      @(posedge pclk);
      tick_n++;
    end while (timer_tick !== 1'h1);
    chk("tick_gap", 8, tick_n);
    report_and_stop;
  end
endmodule : timer16_waveform_mode_control_tb
`default_nettype wire
